//--- rtl/hsfs_fault_supervisor.sv
`timescale 1ns/100ps
`include "hsfs_defines.svh"

module hsfs_fault_supervisor #(
	parameter longint unsigned LOWV_DELAY_CYCLES = `HSFS_LOWV_DELAY_CYCLES,
	parameter longint unsigned COOL_BASE_CYCLES = `HSFS_COOL_BASE_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire hsfs_pkg::hsfs_sense_s sense,
	input wire logic senseValid,
	input wire logic [15:0] senseMicrovolts,
	input wire logic gateCommandOn,
	input wire logic powerGoodLatched,
	input wire logic [1:0] powerGoodIn,
	input wire hsfs_pkg::hsfs_reg_req_s regReq,
	output logic [7:0] regRdData,
	output logic primarySwitchDrive,
	output logic secondarySwitchDrive,
	output logic singleDriverMode,
	output logic [1:0] powerGoodOut,
	output logic alertN
);

	localparam int CW = 40;
	localparam int SW = $bits(hsfs_pkg::hsfs_sense_s);

	// Two-flop synchroniser; stage one is read only by stage two.
	hsfs_pkg::hsfs_sense_s syncA_q, syncB_q;
	logic [1:0] primeCnt_q;
	logic primed;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncA_q <= '0;
			syncB_q <= '0;
			primeCnt_q <= 2'h0;
		end else begin
			syncA_q <= sense;
			syncB_q <= syncA_q;
			if (!primed) begin
				primeCnt_q <= primeCnt_q + 2'h1;
			end
		end
	end

	// Until the synchroniser holds real samples no synchronised status may update.
	assign primed = (primeCnt_q == 2'h2);

	// Register bank.
	logic [7:0] retryPolicy_q, delaySettings_q, miscSettings_q, pinFunc_q, alertMask_q;
	logic [7:0] restartCtl_q, sticky_q, sticky_d, live, inputPins;
	wire wrRetry = regReq.wrEn && regReq.addr == `HSFS_ADDR_RETRY_POLICY;
	wire wrDelay = regReq.wrEn && regReq.addr == `HSFS_ADDR_DELAY_SETTINGS;
	wire wrMisc = regReq.wrEn && regReq.addr == `HSFS_ADDR_MISC_SETTINGS;
	wire wrPin = regReq.wrEn && regReq.addr == `HSFS_ADDR_PIN_FUNCTION_SELECT;
	wire wrAlert = regReq.wrEn && regReq.addr == `HSFS_ADDR_ALERT_MASK;
	wire wrRestart = regReq.wrEn && regReq.addr == `HSFS_ADDR_RESTART_CONTROL;
	wire wrSticky = regReq.wrEn && regReq.addr == `HSFS_ADDR_STICKY_FAULT_LOG;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			retryPolicy_q <= `HSFS_RST_RETRY_POLICY;
			delaySettings_q <= `HSFS_RST_DELAY_SETTINGS;
			miscSettings_q <= `HSFS_RST_MISC_SETTINGS;
			pinFunc_q <= `HSFS_RST_PIN_FUNCTION_SELECT;
			alertMask_q <= `HSFS_RST_ALERT_MASK;
			restartCtl_q <= `HSFS_RST_RESTART_CONTROL;
		end else begin
			if (wrRetry) begin
				retryPolicy_q <= regReq.wrData;
			end
			if (wrDelay) begin
				delaySettings_q <= regReq.wrData;
			end
			if (wrMisc) begin
				miscSettings_q <= regReq.wrData;
			end
			if (wrPin) begin
				pinFunc_q <= regReq.wrData;
			end
			if (wrAlert) begin
				alertMask_q <= regReq.wrData;
			end
			if (wrRestart) begin
				restartCtl_q <= regReq.wrData;
			end
		end
	end

	// Mode pin and output passthrough.
	logic singleMode_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			singleMode_q <= 1'b1;
		end else if (primed) begin
			singleMode_q <= syncB_q.modeFloat;
		end
	end
	assign singleDriverMode = singleMode_q;

	// Power-good is not touched by any fault here.
	assign powerGoodOut = powerGoodIn;

	// Supply-high live condition.
	logic highvLive_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			highvLive_q <= 1'b0;
		end else if (primed) begin
			highvLive_q <= syncB_q.supplyHighSense;
		end
	end

	// Combined undervoltage with both-crossed hysteresis.
	logic lowvLive_q;
	wire bothLow = !syncB_q.undervoltRiseSense && !syncB_q.undervoltFallSense;
	wire bothHigh = syncB_q.undervoltRiseSense && syncB_q.undervoltFallSense;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lowvLive_q <= 1'b0;
		end else if (primed && bothLow) begin
			lowvLive_q <= 1'b1;
		end else if (primed && bothHigh) begin
			lowvLive_q <= 1'b0;
		end
	end

	// Switch-leak check only while the gates are commanded off.
	logic leakLive_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			leakLive_q <= 1'b0;
		end else if (senseValid && !gateCommandOn) begin
			leakLive_q <= senseMicrovolts > `HSFS_LEAK_LIMIT_UV;
		end
	end

	// Output sag.
	logic sagLive_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sagLive_q <= 1'b0;
		end else if (primed) begin
			sagLive_q <= syncB_q.outputSagSense;
		end
	end

	// Pin four function and general-purpose inputs.
	hsfs_pkg::hsfs_pin4_e pin4Sel;
	assign pin4Sel = hsfs_pkg::hsfs_pin4_e'(pinFunc_q[`HSFS_PIN4_SEL_MSB:`HSFS_PIN4_SEL_LSB]);
	wire pin4Trouble = pin4Sel == hsfs_pkg::HSFS_PIN4_TROUBLE_LOW
		|| pin4Sel == hsfs_pkg::HSFS_PIN4_TROUBLE_HIGH;
	wire troubleNow = pin4Sel == hsfs_pkg::HSFS_PIN4_TROUBLE_LOW ? !syncB_q.configPins[3]
		: syncB_q.configPins[3];
	logic troubleLive_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			troubleLive_q <= 1'b0;
		end else if (primed) begin
			troubleLive_q <= pin4Trouble && troubleNow;
		end
	end

	// Pins one to three are general inputs when their select bit is set.
	wire [3:0] gpiSel = {!pin4Trouble, pinFunc_q[2:0]};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gpi
			assign inputPins[gi] = gpiSel[gi] && syncB_q.configPins[gi];
		end
	endgenerate
	assign inputPins[7:4] = 4'h0;

	// Live condition vector.
	always_comb begin
		live = 8'h00;
		live[`HSFS_BIT_HIGHV] = highvLive_q;
		live[`HSFS_BIT_LOWV] = lowvLive_q;
		live[`HSFS_BIT_SWITCH_LEAK] = leakLive_q;
		live[`HSFS_BIT_OUTPUT_SAG] = sagLive_q;
		live[`HSFS_BIT_OUTSIDE_TROUBLE] = troubleLive_q;
	end

	// Sticky log; sets and persisting conditions win over a host write.
	logic [7:0] stickySet;
	always_comb begin
		stickySet = live;
		stickySet[`HSFS_BIT_OUTPUT_SAG] = sagLive_q
			&& (powerGoodLatched || sticky_q[`HSFS_BIT_OUTPUT_SAG]);
		sticky_d = wrSticky ? regReq.wrData : sticky_q;
		sticky_d = sticky_d | stickySet;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sticky_q <= 8'h00;
		end else begin
			sticky_q <= sticky_d;
		end
	end

	// Undervoltage retry delay: held loaded while low, counts down after recovery.
	logic [CW-1:0] lowvCnt_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lowvCnt_q <= '0;
		end else if (lowvLive_q) begin
			lowvCnt_q <= CW'(LOWV_DELAY_CYCLES);
		end else if (lowvCnt_q != '0) begin
			lowvCnt_q <= lowvCnt_q - CW'(1);
		end
	end

	// Outside-trouble cooldown sequence.
	hsfs_pkg::hsfs_state_e state_q, state_d;
	logic [CW-1:0] coolCnt_q, coolCnt_d, coolLoad;
	wire [2:0] coolSel = delaySettings_q[`HSFS_COOL_MSB:`HSFS_COOL_LSB];
	assign coolLoad = CW'(COOL_BASE_CYCLES) << coolSel;

	always_comb begin
		state_d = state_q;
		coolCnt_d = coolCnt_q;
		case (state_q)
			hsfs_pkg::HSFS_ST_IDLE: begin
				if (troubleLive_q) begin
					state_d = hsfs_pkg::HSFS_ST_FAULT;
				end
			end
			hsfs_pkg::HSFS_ST_FAULT: begin
				if (!troubleLive_q) begin
					state_d = hsfs_pkg::HSFS_ST_COOL;
					coolCnt_d = coolLoad;
				end
			end
			hsfs_pkg::HSFS_ST_COOL: begin
				if (troubleLive_q) begin
					state_d = hsfs_pkg::HSFS_ST_FAULT;
				end else if (coolCnt_q <= CW'(1)) begin
					state_d = hsfs_pkg::HSFS_ST_IDLE;
					coolCnt_d = '0;
				end else begin
					coolCnt_d = coolCnt_q - CW'(1);
				end
			end
			default: begin
				state_d = hsfs_pkg::HSFS_ST_IDLE;
				coolCnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= hsfs_pkg::HSFS_ST_IDLE;
			coolCnt_q <= '0;
		end else begin
			state_q <= state_d;
			coolCnt_q <= coolCnt_d;
		end
	end

	wire coolRunning = state_q == hsfs_pkg::HSFS_ST_COOL;

	// Gate permission. With retry off, the sticky bit keeps the switch off as well.
	wire highvBlock = highvLive_q
		|| (!retryPolicy_q[`HSFS_BIT_HIGHV_RETRY] && sticky_q[`HSFS_BIT_HIGHV]);
	wire lowvBlock = lowvLive_q || lowvCnt_q != '0
		|| (!retryPolicy_q[`HSFS_BIT_LOWV_RETRY] && sticky_q[`HSFS_BIT_LOWV]);
	wire troubleBlock = miscSettings_q[`HSFS_BIT_OUTSIDE_SHUTOFF] && (troubleLive_q
		|| coolRunning
		|| (!retryPolicy_q[`HSFS_BIT_OUTSIDE_RETRY]
		&& sticky_q[`HSFS_BIT_OUTSIDE_TROUBLE]));
	// Output sag and general inputs are deliberately absent here.
	wire allow = !(highvBlock || lowvBlock || troubleBlock);

	// Permission waits until the live flags hold real samples, so a fault present at reset
	// release never lets the switch on for a few cycles.
	logic drive_q, ready_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			drive_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			ready_q <= primed;
			drive_q <= allow && ready_q;
		end
	end
	// Both gates share one permission so a fault drops them together.
	assign primarySwitchDrive = drive_q;
	assign secondarySwitchDrive = drive_q;

	// Alert from any enabled sticky bit; general inputs never reach it.
	logic alertN_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			alertN_q <= 1'b1;
		end else begin
			alertN_q <= !(|(sticky_q & alertMask_q));
		end
	end
	assign alertN = alertN_q;

	// Read port.
	logic [7:0] rdMux, restartView;
	always_comb begin
		restartView = restartCtl_q;
		restartView[`HSFS_BIT_DELAY_RUNNING] = coolRunning;
		case (regReq.addr)
			`HSFS_ADDR_INPUT_PIN_STATE: rdMux = inputPins;
			`HSFS_ADDR_LIVE_CONDITION_STATE: rdMux = live;
			`HSFS_ADDR_STICKY_FAULT_LOG: rdMux = sticky_q;
			`HSFS_ADDR_RETRY_POLICY: rdMux = retryPolicy_q;
			`HSFS_ADDR_DELAY_SETTINGS: rdMux = delaySettings_q;
			`HSFS_ADDR_MISC_SETTINGS: rdMux = miscSettings_q;
			`HSFS_ADDR_PIN_FUNCTION_SELECT: rdMux = pinFunc_q;
			`HSFS_ADDR_ALERT_MASK: rdMux = alertMask_q;
			`HSFS_ADDR_RESTART_CONTROL: rdMux = restartView;
			default: rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdData <= 8'h00;
		end else if (regReq.rdEn) begin
			regRdData <= rdMux;
		end
	end

	logic unusedSync;
	assign unusedSync = ^SW;

endmodule : hsfs_fault_supervisor

//--- rtl/hsfs_defines.svh
`ifndef HSFS_DEFINES_SVH
`define HSFS_DEFINES_SVH

// Register offsets.
`define HSFS_ADDR_INPUT_PIN_STATE 8'h02
`define HSFS_ADDR_LIVE_CONDITION_STATE 8'h03
`define HSFS_ADDR_STICKY_FAULT_LOG 8'h04
`define HSFS_ADDR_RETRY_POLICY 8'h0B
`define HSFS_ADDR_DELAY_SETTINGS 8'h0E
`define HSFS_ADDR_MISC_SETTINGS 8'h0F
`define HSFS_ADDR_PIN_FUNCTION_SELECT 8'h10
`define HSFS_ADDR_ALERT_MASK 8'h15
`define HSFS_ADDR_RESTART_CONTROL 8'hA2

// Bit positions shared by live_condition_state, sticky_fault_log and alert_mask.
`define HSFS_BIT_HIGHV 0
`define HSFS_BIT_LOWV 1
`define HSFS_BIT_SWITCH_LEAK 3
`define HSFS_BIT_OUTPUT_SAG 5
`define HSFS_BIT_OUTSIDE_TROUBLE 6

// retry_policy bits.
`define HSFS_BIT_HIGHV_RETRY 0
`define HSFS_BIT_LOWV_RETRY 1
`define HSFS_BIT_OUTSIDE_RETRY 2
// misc_settings bit.
`define HSFS_BIT_OUTSIDE_SHUTOFF 0
// restart_control delay-running bit.
`define HSFS_BIT_DELAY_RUNNING 1
// delay_settings cooldown field [3:1].
`define HSFS_COOL_LSB 1
`define HSFS_COOL_MSB 3
// pin_function_select polarity field [7:6].
`define HSFS_PIN4_SEL_LSB 6
`define HSFS_PIN4_SEL_MSB 7

// Reset values.
`define HSFS_RST_RETRY_POLICY 8'h07
`define HSFS_RST_DELAY_SETTINGS 8'h00
`define HSFS_RST_MISC_SETTINGS 8'h01
`define HSFS_RST_PIN_FUNCTION_SELECT 8'h00
`define HSFS_RST_ALERT_MASK 8'h00
`define HSFS_RST_RESTART_CONTROL 8'h00

// Timing.
`define HSFS_CLK_KHZ 250000
`define HSFS_LOWV_DELAY_MS 128
`define HSFS_COOL_BASE_MS 512
`define HSFS_LOWV_DELAY_CYCLES (`HSFS_LOWV_DELAY_MS * `HSFS_CLK_KHZ)
`define HSFS_COOL_BASE_CYCLES (`HSFS_COOL_BASE_MS * `HSFS_CLK_KHZ)

// Switch-leak limit in microvolts.
`define HSFS_LEAK_LIMIT_UV 16'h00FF

`endif

//--- rtl/hsfs_pkg.sv
package hsfs_pkg;

	// Digitised analog front-end levels, all asynchronous to clk.
	typedef struct packed {
		logic supplyHighSense;
		logic undervoltRiseSense;
		logic undervoltFallSense;
		logic outputSagSense;
		logic modeFloat;
		logic [3:0] configPins;
	} hsfs_sense_s;

	// One register access from the serial engine.
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} hsfs_reg_req_s;

	// Function of config_pin_four, from pin_function_select[7:6].
	typedef enum logic [1:0] {
		HSFS_PIN4_GPI = 2'h0,
		HSFS_PIN4_TROUBLE_LOW = 2'h1,
		HSFS_PIN4_TROUBLE_HIGH = 2'h2,
		HSFS_PIN4_GPI_ALT = 2'h3
	} hsfs_pin4_e;

	// Outside-trouble retry sequence.
	typedef enum logic [2:0] {
		HSFS_ST_IDLE = 3'b001,
		HSFS_ST_FAULT = 3'b010,
		HSFS_ST_COOL = 3'b100
	} hsfs_state_e;

endpackage : hsfs_pkg

//--- tb/hsfs_fault_supervisor_asserts.sv
`timescale 1ns/100ps
module hsfs_fault_supervisor_asserts #(
	parameter longint unsigned LOWV_DELAY_CYCLES = 20
) (
	input wire logic clk,
	input wire logic resetn,
	input wire hsfs_pkg::hsfs_sense_s sense,
	input wire logic senseValid,
	input wire logic [15:0] senseMicrovolts,
	input wire logic gateCommandOn,
	input wire logic powerGoodLatched,
	input wire logic [1:0] powerGoodIn,
	input wire hsfs_pkg::hsfs_reg_req_s regReq,
	input wire logic [7:0] regRdData,
	input wire logic primarySwitchDrive,
	input wire logic secondarySwitchDrive,
	input wire logic singleDriverMode,
	input wire logic [1:0] powerGoodOut,
	input wire logic alertN
);
	// Saturates so that a fresh reset never looks like a recent undervoltage.
	logic [31:0] sinceLow_q;
	logic maskOn_q;
	wire lowBoth = !sense.undervoltRiseSense && !sense.undervoltFallSense;
	wire maskWr = regReq.wrEn && (regReq.addr == 8'h15);
	wire sinceLowSat = (sinceLow_q == 32'hFFFFFFFF);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sinceLow_q <= 32'hFFFFFFFF;
			maskOn_q <= 1'b0;
		end else begin
			sinceLow_q <= lowBoth ? 32'h0 : sinceLow_q + {31'h0, !sinceLowSat};
			maskOn_q <= maskWr ? (regReq.wrData != 8'h00) : maskOn_q;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_highv; sense.supplyHighSense [*8]; endsequence
	sequence s_lowv; lowBoth [*8]; endsequence
	property p_gate_pair; primarySwitchDrive == secondarySwitchDrive; endproperty
	property p_single_mode; sense.modeFloat [*6] |-> singleDriverMode; endproperty
	property p_pg_pass; powerGoodOut == powerGoodIn; endproperty
	property p_highv_off; s_highv |-> !primarySwitchDrive; endproperty
	property p_lowv_off; s_lowv |-> !primarySwitchDrive; endproperty
	property p_lowv_wait; $rose(primarySwitchDrive) |-> sinceLow_q >= LOWV_DELAY_CYCLES; endproperty
	property p_alert_quiet; !maskOn_q && !$past(maskOn_q) |-> alertN; endproperty
	property p_rdata_hold; !$past(regReq.rdEn) |-> $stable(regRdData); endproperty
	a_gate_pair: assert property (p_gate_pair)
		else $error("gate drives differ");
	a_single_mode: assert property (p_single_mode)
		else $error("single driver mode missing");
	a_pg_pass: assert property (p_pg_pass)
		else $error("power good outputs altered");
	a_highv_off: assert property (p_highv_off)
		else $error("gate allowed during supply high");
	a_lowv_off: assert property (p_lowv_off)
		else $error("gate allowed during undervoltage");
	a_lowv_wait: assert property (p_lowv_wait)
		else $error("gate allowed before undervoltage wait");
	a_alert_quiet: assert property (p_alert_quiet)
		else $error("alert without enable");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without read");
endmodule : hsfs_fault_supervisor_asserts

bind hsfs_fault_supervisor hsfs_fault_supervisor_asserts #(
	.LOWV_DELAY_CYCLES(LOWV_DELAY_CYCLES)
) hsfs_fault_supervisor_asserts_i (.clk(clk), .resetn(resetn), .sense(sense),
	.senseValid(senseValid), .senseMicrovolts(senseMicrovolts), .gateCommandOn(gateCommandOn),
	.powerGoodLatched(powerGoodLatched), .powerGoodIn(powerGoodIn), .regReq(regReq),
	.regRdData(regRdData), .primarySwitchDrive(primarySwitchDrive),
	.secondarySwitchDrive(secondarySwitchDrive), .singleDriverMode(singleDriverMode),
	.powerGoodOut(powerGoodOut), .alertN(alertN));

//--- tb/hsfs_afe_model.sv
`timescale 1ns/100ps
module hsfs_afe_model (
	input wire logic clk,
	input wire hsfs_pkg::hsfs_sense_s levels,
	input wire logic adcGo,
	input wire logic [15:0] adcVal,
	output hsfs_pkg::hsfs_sense_s sense,
	output logic senseValid,
	output logic [15:0] senseMicrovolts
);
	// Between conversions the result bus churns, so a stale sample is never mistaken for data.
	logic [15:0] junk_q = 16'hA5A5;
	always @(posedge clk) junk_q <= junk_q + 16'h3C5B;
	assign sense = levels;
	assign senseValid = adcGo;
	assign senseMicrovolts = adcGo ? adcVal : junk_q;
endmodule : hsfs_afe_model

//--- tb/hsfs_fault_supervisor_tb.sv
`timescale 1ns/100ps
module hsfs_fault_supervisor_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	hsfs_pkg::hsfs_sense_s lv = 9'h0DF;
	hsfs_pkg::hsfs_sense_s sense;
	hsfs_pkg::hsfs_reg_req_s regReq = '0;
	logic adcGo = 1'b0;
	logic [15:0] adcVal = 16'h0;
	logic senseValid, primarySwitchDrive, secondarySwitchDrive, singleDriverMode, alertN;
	logic [15:0] senseMicrovolts;
	logic gateCommandOn = 1'b1;
	logic powerGoodLatched = 1'b0;
	logic [1:0] powerGoodIn = 2'h1;
	logic [1:0] powerGoodOut;
	logic [7:0] regRdData;
	int numErrors = 0;
	int totalChecks = 0;
	always #2 clk = ~clk;
	hsfs_afe_model hsfs_afe_model_i (.clk(clk), .levels(lv), .adcGo(adcGo), .adcVal(adcVal),
		.sense(sense), .senseValid(senseValid), .senseMicrovolts(senseMicrovolts));
	hsfs_fault_supervisor #(.LOWV_DELAY_CYCLES(20), .COOL_BASE_CYCLES(10)) hsfs_fault_supervisor_i (
		.clk(clk), .resetn(resetn), .sense(sense), .senseValid(senseValid),
		.senseMicrovolts(senseMicrovolts), .gateCommandOn(gateCommandOn),
		.powerGoodLatched(powerGoodLatched), .powerGoodIn(powerGoodIn), .regReq(regReq),
		.regRdData(regRdData), .primarySwitchDrive(primarySwitchDrive),
		.secondarySwitchDrive(secondarySwitchDrive), .singleDriverMode(singleDriverMode),
		.powerGoodOut(powerGoodOut), .alertN(alertN));
	task automatic testDone();
		$display("checks=%0d errors=%0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : testDone
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
		@(posedge clk);
		regReq.wrEn <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
		@(posedge clk);
		regReq.rdEn <= 1'b0;
		@(posedge clk);
		chk(regRdData, exp);
	endtask : rdchk
	task automatic waitDrive(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && primarySwitchDrive !== v; i++) @(posedge clk);
		chk({7'h0, primarySwitchDrive}, {7'h0, v});
		if (primarySwitchDrive !== v) testDone();
	endtask : waitDrive
	task automatic adc(input logic [15:0] v);
		adcGo <= 1'b1;
		adcVal <= v;
		@(posedge clk);
		adcGo <= 1'b0;
		tick(3);
	endtask : adc
	task automatic doReset();
		resetn <= 1'b0;
		tick(10);
		resetn <= 1'b1;
		tick(6);
	endtask : doReset
	task automatic tRegs();
		rdchk(8'h0B, 8'h07);
		rdchk(8'h0F, 8'h01);
		rdchk(8'h15, 8'h00);
		wr(8'h01, 8'hFF);
		rdchk(8'h01, 8'h00);
		rdchk(8'h04, 8'h00);
		chk({6'h0, singleDriverMode, secondarySwitchDrive}, 8'h03);
	endtask : tRegs
	task automatic tHighv();
		lv.supplyHighSense <= 1'b1;
		powerGoodIn <= 2'h2;
		waitDrive(1'b0, 8);
		chk({6'h0, powerGoodOut}, 8'h02);
		rdchk(8'h03, 8'h01);
		wr(8'h04, 8'h00);
		rdchk(8'h04, 8'h01);
		lv.supplyHighSense <= 1'b0;
		waitDrive(1'b1, 6);
		wr(8'h04, 8'h00);
		rdchk(8'h04, 8'h00);
		wr(8'h0B, 8'h06);
		lv.supplyHighSense <= 1'b1;
		tick(8);
		lv.supplyHighSense <= 1'b0;
		tick(10);
		chk({7'h0, primarySwitchDrive}, 8'h00);
		wr(8'h04, 8'h00);
		waitDrive(1'b1, 8);
		wr(8'h0B, 8'h07);
	endtask : tHighv
	task automatic tLeak();
		gateCommandOn <= 1'b0;
		adc(16'h00FF);
		rdchk(8'h03, 8'h00);
		adc(16'h0100);
		rdchk(8'h03, 8'h08);
		rdchk(8'h04, 8'h08);
		adc(16'h0000);
		wr(8'h04, 8'h00);
		rdchk(8'h04, 8'h00);
		gateCommandOn <= 1'b1;
	endtask : tLeak
	task automatic tSag();
		powerGoodLatched <= 1'b1;
		lv.outputSagSense <= 1'b1;
		tick(6);
		rdchk(8'h03, 8'h20);
		rdchk(8'h04, 8'h20);
		chk({7'h0, primarySwitchDrive}, 8'h01);
		lv.outputSagSense <= 1'b0;
		tick(6);
		rdchk(8'h03, 8'h00);
		wr(8'h04, 8'h00);
		powerGoodLatched <= 1'b0;
	endtask : tSag
	task automatic tTrouble();
		wr(8'h0E, 8'h02);
		wr(8'h10, 8'h40);
		wr(8'h15, 8'h40);
		lv.configPins[3] <= 1'b0;
		waitDrive(1'b0, 8);
		tick(2);
		chk({7'h0, alertN}, 8'h00);
		rdchk(8'h03, 8'h40);
		lv.configPins[3] <= 1'b1;
		tick(5);
		rdchk(8'hA2, 8'h02);
		lv.configPins[3] <= 1'b0;
		tick(4);
		lv.configPins[3] <= 1'b1;
		tick(16);
		chk({7'h0, primarySwitchDrive}, 8'h00);
		waitDrive(1'b1, 20);
		rdchk(8'hA2, 8'h00);
		wr(8'h0F, 8'h00);
		lv.configPins[3] <= 1'b0;
		tick(6);
		chk({7'h0, primarySwitchDrive}, 8'h01);
		chk({7'h0, alertN}, 8'h00);
		lv.configPins[3] <= 1'b1;
		tick(4);
		wr(8'h04, 8'h00);
		tick(2);
		chk({7'h0, alertN}, 8'h01);
		// Let the cooldown started above run out before shutoff is enabled again.
		tick(24);
		wr(8'h0F, 8'h01);
		wr(8'h15, 8'h00);
	endtask : tTrouble
	task automatic tGpi();
		wr(8'h10, 8'h07);
		lv.configPins <= 4'h5;
		tick(6);
		rdchk(8'h02, 8'h05);
		chk({6'h0, primarySwitchDrive, alertN}, 8'h03);
		lv.configPins <= 4'hF;
		wr(8'h10, 8'h00);
	endtask : tGpi
	task automatic tLowv();
		lv.undervoltRiseSense <= 1'b0;
		lv.undervoltFallSense <= 1'b0;
		doReset();
		rdchk(8'h04, 8'h02);
		rdchk(8'h03, 8'h02);
		lv.undervoltRiseSense <= 1'b1;
		tick(6);
		rdchk(8'h03, 8'h02);
		lv.undervoltFallSense <= 1'b1;
		tick(6);
		rdchk(8'h03, 8'h00);
		chk({7'h0, primarySwitchDrive}, 8'h00);
		waitDrive(1'b1, 30);
		wr(8'h04, 8'h00);
		rdchk(8'h04, 8'h00);
	endtask : tLowv
	initial begin
		doReset();
		waitDrive(1'b1, 20);
		tRegs();
		tHighv();
		tLeak();
		tSag();
		tTrouble();
		tGpi();
		tLowv();
		testDone();
	end
endmodule : hsfs_fault_supervisor_tb
